// File: rtl/ros_pkg.sv
package ros_pkg;
  // --------------------------------------------------------------
  // Widths and field layout
  // --------------------------------------------------------------
  localparam int VAL_W = 16;
  localparam int CODE_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // --------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_LOW = 4'h1;
  localparam logic [3:0] OFS_HIGH = 4'h2;
  localparam logic [3:0] OFS_RANGE_MIN = 4'h3;
  localparam logic [3:0] OFS_RANGE_MAX = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;
  localparam logic [3:0] OFS_CODE = 4'h6;
  localparam int CTRL_FUNC_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_RANGE_LSB = 2;
  localparam int CTRL_LOAD_BIT = 4;
  // --------------------------------------------------------------
  // Enumerations and reset values
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    ROS_R0_20MA = 2'h0,
    ROS_R4_20MA = 2'h1,
    ROS_R0_5V = 2'h2,
    ROS_R0_10V = 2'h3
  } ros_range_t;
  localparam logic RST_FUNC = 1'b0;
  localparam logic RST_SRC = 1'b0;
  localparam ros_range_t RST_RANGE = ROS_R4_20MA;
  localparam logic signed [15:0] RST_LOW = 16'shFF38;
  localparam logic signed [15:0] RST_HIGH = 16'sh0514;
  localparam logic signed [15:0] RST_RANGE_MIN = 16'shFF38;
  localparam logic signed [15:0] RST_RANGE_MAX = 16'sh0514;
  // Code full scale; 4 mA is one fifth of 20 mA
  localparam logic [15:0] CODE_FULL = 16'hFFFF;
  localparam logic [15:0] CODE_4MA = 16'h3333;
  // One quotient bit per step; 16 steps give the fraction num*65536/den
  localparam int DIV_STEPS = 16;
endpackage : ros_pkg

// File: rtl/ros_div_if.sv
interface ros_div_if;
  logic start;
  logic [16:0] num;
  logic [16:0] den;
  logic busy;
  logic done;
  logic [16:0] quo;
  modport master (output start, output num, output den, input busy, input done, input quo);
  modport slave (input start, input num, input den, output busy, output done, output quo);
endinterface : ros_div_if

// File: rtl/ros_divider.sv
module ros_divider (
  input wire logic clk_in,
  input wire logic rst_n_in,
  ros_div_if.slave div
);
  // --------------------------------------------------------------
  // Restoring divider, one quotient bit per cycle
  // --------------------------------------------------------------
  logic [16:0] rem_reg, rem_next;
  logic [16:0] quo_reg, quo_next;
  logic [16:0] den_reg, den_next;
  logic [4:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [17:0] trial;

  always_comb begin
    trial = '0;
    rem_next = rem_reg;
    quo_next = quo_reg;
    den_next = den_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (div.start && !busy_reg) begin
      // Numerator below denominator: remainder starts at it, zeros walk in
      rem_next = div.num;
      quo_next = '0;
      den_next = div.den;
      cnt_next = 5'(ros_pkg::DIV_STEPS);
      busy_next = 1'b1;
    end else if (busy_reg) begin
      trial = {rem_reg, 1'b0};
      if (trial >= {1'b0, den_reg}) begin
        rem_next = 17'(trial - {1'b0, den_reg});
        quo_next = {quo_reg[15:0], 1'b1};
      end else begin
        rem_next = trial[16:0];
        quo_next = {quo_reg[15:0], 1'b0};
      end
      cnt_next = 5'(cnt_reg - 5'h01);
      if (cnt_reg == 5'h01) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rem_reg <= '0;
      quo_reg <= '0;
      den_reg <= '0;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      rem_reg <= rem_next;
      quo_reg <= quo_next;
      den_reg <= den_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign div.busy = busy_reg;
  assign div.done = done_reg;
  assign div.quo = quo_reg;
endmodule : ros_divider

// File: rtl/ros_span_map.sv
module ros_span_map (
  input wire logic [1:0] range_in,
  input wire logic [16:0] frac_in,
  output logic [15:0] code_out
);
  // --------------------------------------------------------------
  // Map a 0..65536 fraction onto the chosen range's code span
  // --------------------------------------------------------------
  logic [15:0] base;
  logic [15:0] span;
  logic [32:0] prod;

  always_comb begin
    if (range_in == 2'(ros_pkg::ROS_R4_20MA)) begin
      base = ros_pkg::CODE_4MA;
    end else begin
      base = 16'h0000;
    end
    span = 16'(ros_pkg::CODE_FULL - base);
    prod = 33'(frac_in) * 33'(span);
    code_out = 16'(base + 16'(prod >> 16));
  end
endmodule : ros_span_map

// File: rtl/ros_scaler.sv
// Summary of operation
// - Third output: alarm switch or retransmission code
// - Four ranges, 4-20 mA after reset
// - Low point gives minimum, high gives maximum
// - Low above high inverts the mapping
// - Points reset to -200 and 1300
// - Points clamped to input range, reloaded
// - Points share process value fixed-point format
module ros_scaler (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic signed [15:0] process_value_in,
  input wire logic signed [15:0] control_setpoint_in,
  input wire logic alarm_in,
  output logic [15:0] rdata_out,
  output logic aux_output_three_on_out,
  output logic [15:0] aux_output_three_code_out,
  output logic [1:0] aux_output_three_range_out,
  output logic aux_output_three_retx_out
);
  // --------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------
  logic func_reg, func_next;
  logic src_reg, src_next;
  logic [1:0] range_reg, range_next;
  logic signed [15:0] low_reg, low_next;
  logic signed [15:0] high_reg, high_next;
  logic signed [15:0] rmin_reg, rmin_next;
  logic signed [15:0] rmax_reg, rmax_next;
  logic signed [15:0] wval;

  function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
                                                input logic signed [15:0] lo,
                                                input logic signed [15:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction : clamp

  always_comb begin
    wval = $signed(wdata_in);
    func_next = func_reg;
    src_next = src_reg;
    range_next = range_reg;
    low_next = low_reg;
    high_next = high_reg;
    rmin_next = rmin_reg;
    rmax_next = rmax_reg;
    if (wr_in) begin
      case (addr_in)
        ros_pkg::OFS_CTRL: begin
          func_next = wdata_in[ros_pkg::CTRL_FUNC_BIT];
          src_next = wdata_in[ros_pkg::CTRL_SRC_BIT];
          range_next = wdata_in[ros_pkg::CTRL_RANGE_LSB +: 2];
          if (wdata_in[ros_pkg::CTRL_LOAD_BIT]) begin
            low_next = rmin_reg;
            high_next = rmax_reg;
          end
        end
        ros_pkg::OFS_LOW: low_next = clamp(wval, rmin_reg, rmax_reg);
        ros_pkg::OFS_HIGH: high_next = clamp(wval, rmin_reg, rmax_reg);
        ros_pkg::OFS_RANGE_MIN: rmin_next = wval;
        ros_pkg::OFS_RANGE_MAX: rmax_next = wval;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      func_reg <= ros_pkg::RST_FUNC;
      src_reg <= ros_pkg::RST_SRC;
      range_reg <= 2'(ros_pkg::RST_RANGE);
      low_reg <= ros_pkg::RST_LOW;
      high_reg <= ros_pkg::RST_HIGH;
      rmin_reg <= ros_pkg::RST_RANGE_MIN;
      rmax_reg <= ros_pkg::RST_RANGE_MAX;
    end else begin
      func_reg <= func_next;
      src_reg <= src_next;
      range_reg <= range_next;
      low_reg <= low_next;
      high_reg <= high_next;
      rmin_reg <= rmin_next;
      rmax_reg <= rmax_next;
    end
  end

  // --------------------------------------------------------------
  // Scaling sequence: sample, divide, map
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    ROS_IDLE = 3'h1,
    ROS_WAIT = 3'h2,
    ROS_MAP = 3'h4
  } ros_state_t;

  ros_state_t state_reg, state_next;
  logic [16:0] frac_reg, frac_next;
  logic [15:0] code_reg, code_next;
  logic on_reg, on_next;
  logic [1:0] range_o_reg;
  logic retx_reg;
  logic [15:0] rdata_reg, rdata_next;
  logic alarm_s1_reg, alarm_s2_reg;
  logic signed [15:0] src_val;
  logic signed [16:0] num_s, den_s;
  logic inv;
  logic [15:0] mapped;

  ros_div_if div ();

  ros_divider u_div (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .div(div)
  );

  ros_span_map u_map (
    .range_in(range_reg),
    .frac_in(frac_reg),
    .code_out(mapped)
  );

  always_comb begin
    src_val = src_reg ? control_setpoint_in : process_value_in;
    inv = low_reg > high_reg;
    // Same fixed-point unit for points and source; plain signed math
    if (inv) begin
      num_s = 17'(low_reg) - 17'(src_val);
      den_s = 17'(low_reg) - 17'(high_reg);
    end else begin
      num_s = 17'(src_val) - 17'(low_reg);
      den_s = 17'(high_reg) - 17'(low_reg);
    end
  end

  assign div.start = (state_reg == ROS_IDLE) && func_reg && (den_s > 17'sh00000)
                     && (num_s > 17'sh00000) && (num_s < den_s);
  // Only 0 < num < den reaches the divider; fraction = num*65536/den
  assign div.num = 17'(num_s);
  assign div.den = 17'(den_s);

  always_comb begin
    state_next = state_reg;
    frac_next = frac_reg;
    case (state_reg)
      ROS_IDLE: begin
        if (func_reg) begin
          if (den_s == 17'sh00000 || num_s <= 17'sh00000) begin
            frac_next = 17'h00000;
            state_next = ROS_MAP;
          end else if (num_s >= den_s) begin
            frac_next = 17'h10000;
            state_next = ROS_MAP;
          end else begin
            state_next = ROS_WAIT;
          end
        end
      end
      ROS_WAIT: begin
        if (div.done) begin
          frac_next = div.quo;
          state_next = ROS_MAP;
        end
      end
      ROS_MAP: state_next = ROS_IDLE;
      default: state_next = ROS_IDLE;
    endcase
  end

  // Code takes a new value only in MAP and clears in alarm mode, so a half-done divide never shows
  always_comb begin
    code_next = code_reg;
    if (!func_reg) begin
      code_next = 16'h0000;
    end else if (state_reg == ROS_MAP) begin
      code_next = mapped;
    end
    on_next = func_reg ? 1'b0 : alarm_s2_reg;
    case (addr_in)
      ros_pkg::OFS_CTRL: rdata_next = {11'h000, 1'b0, range_reg, src_reg, func_reg};
      ros_pkg::OFS_LOW: rdata_next = low_reg;
      ros_pkg::OFS_HIGH: rdata_next = high_reg;
      ros_pkg::OFS_RANGE_MIN: rdata_next = rmin_reg;
      ros_pkg::OFS_RANGE_MAX: rdata_next = rmax_reg;
      ros_pkg::OFS_STATUS: rdata_next = {13'h0000, state_reg == ROS_WAIT, inv, on_reg};
      ros_pkg::OFS_CODE: rdata_next = code_reg;
      default: rdata_next = 16'h0000;
    endcase
    if (!rd_in) begin
      rdata_next = 16'h0000;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ROS_IDLE;
      frac_reg <= '0;
      code_reg <= '0;
      on_reg <= 1'b0;
      range_o_reg <= 2'(ros_pkg::RST_RANGE);
      retx_reg <= 1'b0;
      rdata_reg <= '0;
      alarm_s1_reg <= 1'b0;
      alarm_s2_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      frac_reg <= frac_next;
      code_reg <= code_next;
      on_reg <= on_next;
      range_o_reg <= range_reg;
      retx_reg <= func_reg;
      rdata_reg <= rdata_next;
      alarm_s1_reg <= alarm_in;
      alarm_s2_reg <= alarm_s1_reg;
    end
  end

  assign rdata_out = rdata_reg;
  assign aux_output_three_on_out = on_reg;
  assign aux_output_three_code_out = code_reg;
  assign aux_output_three_range_out = range_o_reg;
  assign aux_output_three_retx_out = retx_reg;
endmodule : ros_scaler

// File: bench/ros_dc_model.sv
module ros_dc_model (
  input wire logic [15:0] code_in,
  input wire logic [1:0] range_in,
  input wire logic retx_in,
  output logic [15:0] level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Level in uA for current ranges, mV for voltage ranges; dead when not retransmitting
  logic [31:0] full;
  always_comb begin
    full = (range_in == 2'h2) ? 32'd5000 : ((range_in == 2'h3) ? 32'd10000 : 32'd20000);
    level_out = retx_in ? 16'((32'(code_in) * full) / 32'd65535) : 16'h0000;
  end
endmodule : ros_dc_model

// File: bench/ros_scaler_chk.sv
module ros_scaler_chk (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic signed [15:0] process_value_in,
  input wire logic signed [15:0] control_setpoint_in,
  input wire logic alarm_in,
  input wire logic [15:0] rdata_out,
  input wire logic aux_output_three_on_out,
  input wire logic [15:0] aux_output_three_code_out,
  input wire logic [1:0] aux_output_three_range_out,
  input wire logic aux_output_three_retx_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic ctrl_wr;
  assign ctrl_wr = wr_in && (addr_in == ros_pkg::OFS_CTRL);
  a_retx_no_switch: assert property (aux_output_three_retx_out && $past(aux_output_three_retx_out) |-> !aux_output_three_on_out) else $error("switch on in retx mode");
  a_alarm_code_zero: assert property ((!aux_output_three_retx_out)[*3] |-> aux_output_three_code_out == 16'h0000) else $error("code not zero in alarm mode");
  a_alarm_follows: assert property ((!aux_output_three_retx_out && alarm_in)[*5] |=> aux_output_three_on_out || aux_output_three_retx_out) else $error("alarm not followed");
  a_alarm_drops: assert property ((!alarm_in)[*5] |=> !aux_output_three_on_out) else $error("switch on without alarm");
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000) else $error("read data outside read slot");
  a_read_code: assert property ($past(rd_in) && $past(addr_in) == ros_pkg::OFS_CODE |-> rdata_out == $past(aux_output_three_code_out)) else $error("code readback differs");
  a_range_cause: assert property ($changed(aux_output_three_range_out) |-> $past(ctrl_wr) || $past(ctrl_wr, 2)) else $error("range changed without write");
  a_func_cause: assert property ($changed(aux_output_three_retx_out) |-> $past(ctrl_wr) || $past(ctrl_wr, 2)) else $error("function changed without write");
endmodule : ros_scaler_chk

// File: bench/ros_scaler_test.sv
module ros_scaler_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr, rd, alarm, on, retx;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, code, level, d, mn;
  logic signed [15:0] pv, sp;
  logic [1:0] rng;
  int num_errors = 0;
  int n_compared = 0;
  logic [15:0] lvl [4] = '{16'h4E20, 16'h4E20, 16'h1388, 16'h2710};
  ros_scaler dut_u (.sys_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .process_value_in(pv), .control_setpoint_in(sp), .alarm_in(alarm),
    .rdata_out(rdata), .aux_output_three_on_out(on), .aux_output_three_code_out(code),
    .aux_output_three_range_out(rng), .aux_output_three_retx_out(retx));
  ros_dc_model dc_u (.code_in(code), .range_in(rng), .retx_in(retx), .level_out(level));
  always #50 clk = ~clk;
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16
  // Interpolation is coarse, so mid-span values get a window
  task automatic chk_near(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if ((^got === 1'bx) || (got > exp + 16'h0200) || (got + 16'h0200 < exp)) begin
      num_errors++;
      $display("FAIL t=%0t got=%h near=%h", $time, got, exp);
    end
  endtask : chk_near
  // A divide already under way may delay the new value by a full loop
  task automatic drive(input logic [15:0] v, input logic a);
    @(posedge clk);
    pv <= v;
    alarm <= a;
    repeat (60) @(posedge clk);
    @(negedge clk);
  endtask : drive
  function automatic logic [15:0] ctrl(input logic f, input logic s, input logic [1:0] r);
    return {12'h000, r, s, f};
  endfunction : ctrl
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    clk = 0; rst_n = 0; addr = 0; wdata = 0; wr = 0; rd = 0; pv = 0; sp = 0; alarm = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(ros_pkg::OFS_LOW, d); chk16(d, 16'hFF38);
    rd_reg(ros_pkg::OFS_HIGH, d); chk16(d, 16'h0514);
    chk16({14'h0, rng}, 16'h0001);
    chk16({15'h0, retx}, 16'h0000);
    drive(16'h0000, 1'b1); chk16({15'h0, on}, 16'h0001);
    drive(16'h0000, 1'b0); chk16({15'h0, on}, 16'h0000);
    $display("test reset_alarm done");
    for (int r = 0; r < 4; r++) begin
      mn = (r == 1) ? ros_pkg::CODE_4MA : 16'h0000;
      wr_reg(ros_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 2'(r)));
      drive(16'hFF38, 1'b0); chk16(code, mn);
      chk16({15'h0, retx}, 16'h0001);
      drive(16'h0514, 1'b0); chk16(code, 16'hFFFF);
      chk_near(level, lvl[r]);
      drive(16'h0226, 1'b0); chk_near(code, mn + (16'hFFFF - mn) / 2);
      drive(16'h07D0, 1'b0); chk16(code, 16'hFFFF);
      drive(16'hFC18, 1'b0); chk16(code, mn);
    end
    drive(16'h0514, 1'b1); chk16({15'h0, on}, 16'h0000);
    rd_reg(ros_pkg::OFS_CODE, d); chk16(d, 16'hFFFF);
    $display("test ranges done");
    wr_reg(ros_pkg::OFS_CTRL, ctrl(1'b1, 1'b1, 2'h1)); sp <= 16'h0514;
    drive(16'hFF38, 1'b0); chk16(code, 16'hFFFF);
    wr_reg(ros_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 2'h1));
    drive(16'hFF38, 1'b0); chk16(code, 16'h3333);
    wr_reg(ros_pkg::OFS_CTRL, ctrl(1'b0, 1'b1, 2'h1));
    drive(16'hFF38, 1'b0); chk16(code, 16'h0000);
    $display("test source done");
    wr_reg(ros_pkg::OFS_LOW, 16'h0514); wr_reg(ros_pkg::OFS_HIGH, 16'hFF38);
    wr_reg(ros_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 2'h1));
    drive(16'hFF38, 1'b0); chk16(code, 16'hFFFF);
    drive(16'h0514, 1'b0); chk16(code, 16'h3333);
    wr_reg(ros_pkg::OFS_LOW, 16'h0064); wr_reg(ros_pkg::OFS_HIGH, 16'h0064);
    drive(16'h0064, 1'b0); chk16(code, 16'h3333);
    $display("test invert_equal done");
    wr_reg(ros_pkg::OFS_LOW, 16'hEC78); rd_reg(ros_pkg::OFS_LOW, d); chk16(d, 16'hFF38);
    wr_reg(ros_pkg::OFS_HIGH, 16'h1388); rd_reg(ros_pkg::OFS_HIGH, d); chk16(d, 16'h0514);
    wr_reg(ros_pkg::OFS_RANGE_MIN, 16'h0000); wr_reg(ros_pkg::OFS_RANGE_MAX, 16'h03E8);
    wr_reg(ros_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 2'h0) | 16'h0010);
    rd_reg(ros_pkg::OFS_LOW, d); chk16(d, 16'h0000);
    rd_reg(ros_pkg::OFS_HIGH, d); chk16(d, 16'h03E8);
    drive(16'h01F4, 1'b0); chk_near(code, 16'h7FFF);
    drive(16'h03E8, 1'b0); chk16(code, 16'hFFFF);
    rd_reg(4'hF, d); chk16(d, 16'h0000);
    $display("test clamp_reload done");
    final_report();
  end
  initial begin
    #3000000;
    num_errors++;
    final_report();
  end
endmodule : ros_scaler_test
bind ros_scaler ros_scaler_chk chk_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .process_value_in(process_value_in), .control_setpoint_in(control_setpoint_in),
  .alarm_in(alarm_in), .rdata_out(rdata_out), .aux_output_three_on_out(aux_output_three_on_out),
  .aux_output_three_code_out(aux_output_three_code_out),
  .aux_output_three_range_out(aux_output_three_range_out),
  .aux_output_three_retx_out(aux_output_three_retx_out));
